// ===== src/ccf_top.v
// ccf_top: control and feedback bit logic of a counter channel,
// with an apb slave holding the control image and feedback image.
// assumes a single pclk domain; fault and comparator inputs are
// synchronous to pclk; the counting core sits outside this block.
`include "ccf_defs.vh"

module ccf_top #(
	parameter [31:0] VALUE_MAX = 32'h7fffffff  // highest legal count value
) (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// fault and core inputs
	input  wire        supply_short_in,
	input  wire        out_one_fault_in,
	input  wire        param_invalid_in,
	input  wire        sync_event_in,
	input  wire        compare_one_hit,
	input  wire        compare_two_hit,
	input  wire        count_dir_up,
	input  wire        count_dir_down,
	// outputs towards pins and core
	output wire        digital_out_one,
	output wire        digital_out_two,
	output wire        gate_open,
	output wire        diag_message,
	output wire [31:0] count_value
);

	// number of set bits in a command vector
	function [2:0] ccf_ones;
		input [4:0] v;
		begin
			ccf_ones = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]}
				+ {2'h0, v[3]} + {2'h0, v[4]};
		end
	endfunction

	// a load or comparison value is legal within the count range
	function ccf_valid;
		input [31:0] v;
		begin
			ccf_valid = (v <= VALUE_MAX);
		end
	endfunction

	// software visible storage
	reg  [31:0] value_reg;        // value field, bytes 0 to 3
	reg  [12:0] ctrl_reg;         // control bytes 4 and 5
	reg  [31:0] count_reg;        // current count
	reg  [31:0] pending_reg;      // preparatory load value
	reg  [31:0] cmp_one_reg;      // comparison value 1
	reg  [31:0] cmp_two_reg;      // comparison value 2
	reg  [2:0]  func_one_reg;     // output one function code
	reg  [1:0]  func_two_reg;     // output two function code
	reg  [7:0]  hyst_reg;         // hysteresis for both outputs
	reg  [7:0]  pulse_reg;        // pulse duration, 2 ms units
	// feedback flags
	reg         supply_err_reg;   // latched encoder supply fault
	reg         one_fault_reg;    // latched output one fault
	reg         load_err_reg;     // load function error
	reg         param_err_reg;    // parameter assignment error
	reg         rst_active_reg;   // status reset in progress
	reg         cmp_one_sts_reg;  // comparator one status
	reg         cmp_two_sts_reg;  // comparator two status
	reg         sync_sts_reg;     // synchronization done
	reg         up_reg;           // registered up direction
	reg         down_reg;         // registered down direction
	// edge history
	reg  [4:0]  cmd_prev_reg;     // commands seen last cycle
	reg         man_one_prev_reg; // manual one bit last cycle
	reg         man_two_prev_reg; // manual two bit last cycle
	// pin side outputs
	reg         out_one_reg;      // digital output one
	reg         out_two_reg;      // digital output two
	reg         gate_reg;         // software gate state
	reg         diag_reg;         // diagnostic message level
	// apb answer
	reg         pready_reg;       // high during every access phase
	reg         pslverr_reg;      // unmapped address flag
	reg  [31:0] prdata_reg;       // read data captured at setup

	// apb decode
	wire        setup_phase;      // setup cycle seen at this edge
	wire        bus_write;        // write takes effect at this edge
	wire        addr_known;       // address hits a register
	reg  [31:0] read_mux;         // read data for the setup address
	reg  [31:0] feedback_word;    // assembled feedback image

	// command decode
	wire [4:0]  cmd_now;          // command bits as written
	wire [4:0]  cmd_rise;         // rising command bits
	wire        any_rise;         // some command was issued
	wire        multi_cmd;        // more than one command set
	wire        param_bad;        // output parameter bytes illegal
	wire        switch_bad;       // switch mode cannot work
	wire        value_ok;         // value field in range
	wire        cmd_accept;       // the single command is carried out
	wire        cmd_refuse;       // the command is rejected
	wire        ack;              // error acknowledge bit
	wire        man_one_rise;     // manual one bit toggled on
	wire        man_one_fall;     // manual one bit toggled off
	wire        man_two_rise;     // manual two bit toggled on
	wire        man_two_fall;     // manual two bit toggled off
	wire        out_one_next;     // next level of output one
	wire        out_two_next;     // next level of output two

	assign setup_phase = psel & ~penable;
	assign bus_write   = psel & penable & pready_reg & pwrite;
	assign addr_known  = (paddr[7:5] == 3'h0) & (paddr[1:0] == 2'h0);

	// feedback image built from the flags
	always @* begin
		feedback_word = `CCF_RST_WORD;
		feedback_word[`CCF_F_SUPPLY]     = supply_err_reg;
		feedback_word[`CCF_F_ONE_FAULT]  = one_fault_reg;
		feedback_word[`CCF_F_LOAD_ERR]   = load_err_reg;
		feedback_word[`CCF_F_PARAM_ERR]  = param_err_reg;
		feedback_word[`CCF_F_RST_ACTIVE] = rst_active_reg;
		feedback_word[`CCF_F_CMP_ONE]    = cmp_one_sts_reg;
		feedback_word[`CCF_F_CMP_TWO]    = cmp_two_sts_reg;
		feedback_word[`CCF_F_SYNC]       = sync_sts_reg;
		feedback_word[`CCF_F_OUT_ONE]    = out_one_reg;
		feedback_word[`CCF_F_OUT_TWO]    = out_two_reg;
		feedback_word[`CCF_F_GATE]       = gate_reg;
		feedback_word[`CCF_F_UP]         = up_reg;
		feedback_word[`CCF_F_DOWN]       = down_reg;
	end

	// read multiplexer, unmapped addresses read zero
	always @* begin
		case (paddr)
		`CCF_ADDR_VALUE:    read_mux = value_reg;
		`CCF_ADDR_CTRL:     read_mux = {19'h0, ctrl_reg};
		`CCF_ADDR_FEEDBACK: read_mux = feedback_word;
		`CCF_ADDR_COUNT:    read_mux = count_reg;
		`CCF_ADDR_PENDING:  read_mux = pending_reg;
		`CCF_ADDR_CMP_ONE:  read_mux = cmp_one_reg;
		`CCF_ADDR_CMP_TWO:  read_mux = cmp_two_reg;
		`CCF_ADDR_OUTPARAM: read_mux = {8'h0, pulse_reg, hyst_reg,
			2'h0, func_two_reg, 1'b0, func_one_reg};
		default:            read_mux = `CCF_RST_WORD;
		endcase
	end

	// apb answer: ready in every access phase, zero wait states
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= `CCF_RST_WORD;
		end else begin
			pready_reg  <= setup_phase;
			if (setup_phase) begin
				pslverr_reg <= ~addr_known;
				prdata_reg  <= pwrite ? `CCF_RST_WORD : read_mux;
			end
		end
	end

	// software writes: only the value field and control word are writable
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_reg <= `CCF_RST_WORD;
			ctrl_reg  <= 13'h0000;
		end else if (bus_write) begin
			if (paddr == `CCF_ADDR_VALUE)
				value_reg <= pwdata;
			else if (paddr == `CCF_ADDR_CTRL)
				ctrl_reg  <= pwdata[`CCF_C_USED_HI:0];
		end
	end

	// command decode on the control image
	assign cmd_now    = ctrl_reg[`CCF_C_CMD_HI:`CCF_C_CMD_LO];
	assign cmd_rise   = cmd_now & ~cmd_prev_reg;
	assign any_rise   = |cmd_rise;
	assign multi_cmd  = ccf_ones(cmd_now) > 3'h1;
	assign value_ok   = ccf_valid(value_reg);
	// blocked codes and nonzero reserve bits are refused
	assign param_bad  = (value_reg[`CCF_P_FUNC1_HI:0] > `CCF_FN_SWITCH)
		| value_reg[`CCF_P_RSV_BIT3] | value_reg[`CCF_P_RSV_BIT6]
		| value_reg[`CCF_P_RSV_BIT7]
		| (|value_reg[`CCF_P_RES3_HI:`CCF_P_RES3_LO]);
	// switching between values needs a window with one below two
	assign switch_bad = (value_reg[`CCF_P_FUNC1_HI:0] == `CCF_FN_SWITCH)
		& ~(cmp_one_reg < cmp_two_reg);
	assign cmd_refuse = any_rise & (multi_cmd
		| (cmd_rise[`CCF_K_OUTPARAM] & (param_bad | switch_bad))
		| (~cmd_rise[`CCF_K_OUTPARAM] & ~value_ok));
	assign cmd_accept = any_rise & ~cmd_refuse;

	// command edge history
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cmd_prev_reg <= `CCF_RST_CMD;
		else
			cmd_prev_reg <= cmd_now;
	end

	// count and pending load value
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg   <= `CCF_RST_WORD;
			pending_reg <= `CCF_RST_WORD;
		end else begin
			if (cmd_accept & cmd_rise[`CCF_K_DIRECT])
				count_reg <= value_reg;
			else if (sync_event_in & ctrl_reg[`CCF_C_SYNC_EN])
				count_reg <= pending_reg;
			if (cmd_accept & cmd_rise[`CCF_K_PREP])
				pending_reg <= value_reg;
		end
	end

	// comparison values
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_one_reg <= `CCF_RST_WORD;
			cmp_two_reg <= `CCF_RST_WORD;
		end else begin
			if (cmd_accept & cmd_rise[`CCF_K_CMP_ONE])
				cmp_one_reg <= value_reg;
			if (cmd_accept & cmd_rise[`CCF_K_CMP_TWO])
				cmp_two_reg <= value_reg;
		end
	end

	// output function, hysteresis and pulse duration
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_one_reg <= `CCF_FN_PLAIN;
			func_two_reg <= 2'h0;
			hyst_reg     <= 8'h00;
			pulse_reg    <= 8'h00;
		end else if (cmd_accept & cmd_rise[`CCF_K_OUTPARAM]) begin
			func_one_reg <= value_reg[`CCF_P_FUNC1_HI:0];
			func_two_reg <= value_reg[`CCF_P_FUNC2_HI:`CCF_P_FUNC2_LO];
			hyst_reg     <= value_reg[`CCF_P_HYST_HI:`CCF_P_HYST_LO];
			pulse_reg    <= value_reg[`CCF_P_PULSE_HI:`CCF_P_PULSE_LO];
		end
	end

	// load error: set on refusal, cleared by the next good command
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			load_err_reg <= 1'b0;
		else if (cmd_refuse)
			load_err_reg <= 1'b1;
		else if (cmd_accept)
			load_err_reg <= 1'b0;
	end

	// latched faults; a present cause wins over the acknowledge
	assign ack = ctrl_reg[`CCF_C_ERR_ACK];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_err_reg <= 1'b0;
			one_fault_reg  <= 1'b0;
			param_err_reg  <= 1'b0;
			diag_reg       <= 1'b0;
		end else begin
			if (supply_short_in)
				supply_err_reg <= 1'b1;
			else if (ack)
				supply_err_reg <= 1'b0;
			if (out_one_fault_in)
				one_fault_reg <= 1'b1;
			else if (ack)
				one_fault_reg <= 1'b0;
			if (param_invalid_in)
				param_err_reg <= 1'b1;
			else if (ack)
				param_err_reg <= 1'b0;
			// diagnostic message stands while a supply or output one fault is present or latched
			diag_reg <= (supply_short_in | supply_err_reg)
				| (out_one_fault_in | one_fault_reg);
		end
	end

	// manual switch edges
	assign man_one_rise = ctrl_reg[`CCF_C_ONE_MANUAL] & ~man_one_prev_reg;
	assign man_one_fall = ~ctrl_reg[`CCF_C_ONE_MANUAL] & man_one_prev_reg;
	assign man_two_rise = ctrl_reg[`CCF_C_TWO_MANUAL] & ~man_two_prev_reg;
	assign man_two_fall = ~ctrl_reg[`CCF_C_TWO_MANUAL] & man_two_prev_reg;

	// outputs: plain mode follows the manual bit, else the comparator;
	// a disabled output is forced off
	assign out_one_next = ctrl_reg[`CCF_C_ONE_ENABLE] &
		((func_one_reg == `CCF_FN_PLAIN) ?
		ctrl_reg[`CCF_C_ONE_MANUAL] : compare_one_hit);
	assign out_two_next = ctrl_reg[`CCF_C_TWO_ENABLE] &
		((func_two_reg == 2'h0) ?
		ctrl_reg[`CCF_C_TWO_MANUAL] : compare_two_hit);

	// pin side registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_one_reg      <= 1'b0;
			out_two_reg      <= 1'b0;
			gate_reg         <= 1'b0;
			man_one_prev_reg <= 1'b0;
			man_two_prev_reg <= 1'b0;
			up_reg           <= 1'b0;
			down_reg         <= 1'b0;
		end else begin
			out_one_reg      <= out_one_next;
			out_two_reg      <= out_two_next;
			gate_reg         <= ctrl_reg[`CCF_C_GATE];
			man_one_prev_reg <= ctrl_reg[`CCF_C_ONE_MANUAL];
			man_two_prev_reg <= ctrl_reg[`CCF_C_TWO_MANUAL];
			up_reg           <= count_dir_up;
			down_reg         <= count_dir_down;
		end
	end

	// status reset handshake: active follows the request
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rst_active_reg <= 1'b0;
		else
			rst_active_reg <= ctrl_reg[`CCF_C_STS_RESET];
	end

	// comparator and sync status; a set wins over the reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_one_sts_reg <= 1'b0;
			cmp_two_sts_reg <= 1'b0;
			sync_sts_reg    <= 1'b0;
		end else begin
			if (out_one_reg | (~ctrl_reg[`CCF_C_ONE_ENABLE]
				& (man_one_rise | man_one_fall)))
				cmp_one_sts_reg <= 1'b1;
			else if (rst_active_reg)
				cmp_one_sts_reg <= 1'b0;
			if (out_two_reg | (~ctrl_reg[`CCF_C_TWO_ENABLE]
				& (man_two_rise | man_two_fall)))
				cmp_two_sts_reg <= 1'b1;
			else if (rst_active_reg)
				cmp_two_sts_reg <= 1'b0;
			if (sync_event_in & ctrl_reg[`CCF_C_SYNC_EN])
				sync_sts_reg <= 1'b1;
			else if (rst_active_reg)
				sync_sts_reg <= 1'b0;
		end
	end

	// output ports, each from a flip-flop
	assign prdata          = prdata_reg;
	assign pready          = pready_reg;
	assign pslverr         = pslverr_reg;
	assign digital_out_one = out_one_reg;
	assign digital_out_two = out_two_reg;
	assign gate_open       = gate_reg;
	assign diag_message    = diag_reg;
	assign count_value     = count_reg;

endmodule

// ===== src/ccf_defs.vh
// ccf_defs.vh: offsets, field positions and reset values for ccf_top.
// assumes inclusion by bare name from the design file only.
`ifndef CCF_DEFS_VH
`define CCF_DEFS_VH

// register byte offsets (word aligned)
`define CCF_ADDR_VALUE     8'h00
`define CCF_ADDR_CTRL      8'h04
`define CCF_ADDR_FEEDBACK  8'h08
`define CCF_ADDR_COUNT     8'h0c
`define CCF_ADDR_PENDING   8'h10
`define CCF_ADDR_CMP_ONE   8'h14
`define CCF_ADDR_CMP_TWO   8'h18
`define CCF_ADDR_OUTPARAM  8'h1c

// control word, byte 4 of the control image in bits 7..0
`define CCF_C_GATE         0
`define CCF_C_SYNC_EN      1
`define CCF_C_STS_RESET    2
`define CCF_C_ONE_MANUAL   3
`define CCF_C_ONE_ENABLE   4
`define CCF_C_TWO_MANUAL   5
`define CCF_C_TWO_ENABLE   6
`define CCF_C_ERR_ACK      7
// byte 5 commands in bits 12..8
`define CCF_C_CMD_LO       8
`define CCF_C_CMD_HI       12
`define CCF_C_USED_HI      12
// command vector bit positions
`define CCF_K_DIRECT       0
`define CCF_K_PREP         1
`define CCF_K_CMP_ONE      2
`define CCF_K_CMP_TWO      3
`define CCF_K_OUTPARAM     4

// feedback word bit positions
`define CCF_F_SUPPLY       0
`define CCF_F_ONE_FAULT    1
`define CCF_F_LOAD_ERR     2
`define CCF_F_PARAM_ERR    3
`define CCF_F_RST_ACTIVE   4
`define CCF_F_CMP_ONE      5
`define CCF_F_CMP_TWO      6
`define CCF_F_SYNC         7
`define CCF_F_OUT_ONE      8
`define CCF_F_OUT_TWO      9
`define CCF_F_GATE         10
`define CCF_F_UP           11
`define CCF_F_DOWN         12

// output parameter byte fields
`define CCF_P_FUNC1_HI     2
`define CCF_P_FUNC2_LO     4
`define CCF_P_FUNC2_HI     5
`define CCF_P_HYST_LO      8
`define CCF_P_HYST_HI      15
`define CCF_P_PULSE_LO     16
`define CCF_P_PULSE_HI     23
`define CCF_P_RES3_LO      24
`define CCF_P_RES3_HI      31
`define CCF_P_RSV_BIT3     3
`define CCF_P_RSV_BIT6     6
`define CCF_P_RSV_BIT7     7

// output function codes
`define CCF_FN_PLAIN       3'h0
`define CCF_FN_SWITCH      3'h4

// reset values
`define CCF_RST_WORD       32'h00000000
`define CCF_RST_CMD        5'h00

`endif

// ===== test/ccf_assertions.sv
// ccf_assertions.sv: concurrent checks on the ports of ccf_top.
// assumes a bind from the bench top and a single pclk domain.
module ccf_assertions #(
	parameter logic [31:0] VALUE_MAX = 32'h7fffffff // highest legal value
) (
	// clock and reset
	input logic        pclk,
	input logic        presetn,
	// apb slave side
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	// fault and core side
	input logic        supply_short_in,
	// pins and core outputs
	input logic        digital_out_one,
	input logic        digital_out_two,
	input logic        gate_open,
	input logic        diag_message,
	input logic [31:0] count_value
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [12:0] ctl_reg; // shadow of the control word
	logic [31:0] val_reg; // shadow of the value field
	logic        acc;     // access completes this cycle
	assign acc = psel && penable && pready;

	// shadows follow completed writes, as the slave registers do
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_reg <= 13'h0000;
			val_reg <= 32'h00000000;
		end else if (acc && pwrite && paddr == 8'h04) begin
			ctl_reg <= pwdata[12:0];
		end else if (acc && pwrite && paddr == 8'h00) begin
			val_reg <= pwdata;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	ready_access_a: assert property (psel && !penable |=> pready)
		else $error("no ready in access phase");
	unmapped_err_a: assert property (acc && !pwrite && paddr > 8'h1c
		|-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
	gate_follow_a: assert property (gate_open == $past(ctl_reg[0]))
		else $error("gate does not follow control bit");
	out_one_en_a: assert property (digital_out_one |-> $past(ctl_reg[4]))
		else $error("output one on while disabled");
	out_two_en_a: assert property (digital_out_two |-> $past(ctl_reg[6]))
		else $error("output two on while disabled");
	direct_load_a: assert property ($rose(ctl_reg[8]) && ctl_reg[12:9] == 4'h0
		&& val_reg <= VALUE_MAX |-> ##[1:3] count_value == val_reg)
		else $error("direct load not applied");
	prep_hold_a: assert property ($rose(ctl_reg[9]) && !ctl_reg[1]
		|=> $stable(count_value) [*3]) else $error("count moved on prepare");
	sync_off_a: assert property (!ctl_reg[1] && !$past(ctl_reg[1])
		&& !ctl_reg[8] && !$past(ctl_reg[8]) && !$past(ctl_reg[8], 2)
		|=> $stable(count_value)) else $error("count moved without sync");
	reset_active_a: assert property (acc && !pwrite && paddr == 8'h08
		&& ctl_reg[2] && $past(ctl_reg[2]) && $past(ctl_reg[2], 2)
		&& $past(ctl_reg[2], 3) |-> prdata[4]) else $error("no reset active");
	err_latch_a: assert property (diag_message && !ctl_reg[7]
		&& !$past(ctl_reg[7]) |=> diag_message) else $error("fault not held");
	diag_rise_a: assert property ($rose(supply_short_in)
		|-> ##[1:2] diag_message) else $error("no diagnostic on supply short");
endmodule

// ===== test/ccf_host.sv
// ccf_host.sv: host side model, an apb master moving whole words.
// assumes the slave answers with pready and gives pslverr with it.
module ccf_host (
	// clock
	input  logic        pclk,
	// apb master side
	output logic        psel,
	output logic        penable,
	output logic        pwrite,
	output logic [7:0]  paddr,
	output logic [31:0] pwdata,
	input  logic [31:0] prdata,
	input  logic        pready,
	input  logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// setup, then access held until pready is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines turn over so stale values are never trusted
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// ===== test/tb.sv
// tb.sv: self-checking bench for ccf_top against a reference model.
// assumes ccf_host drives apb; the bench drives the core inputs.
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin n_fail++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, x); end end

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] VMAX = 32'h0000ffff; // small legal range
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, count_value;
	logic        supply_short_in, out_one_fault_in, param_invalid_in;
	logic        sync_event_in, compare_one_hit, compare_two_hit;
	logic        count_dir_up, count_dir_down, gate_open, diag_message;
	logic        digital_out_one, digital_out_two;
	int          n_fail, cmp_count;
	logic [12:0] ctl;                         // control word held by host
	logic [31:0] m_cnt, m_pend, m_c1, m_c2, m_op; // reference registers
	logic        m_lerr;                      // reference load error
	logic [31:0] vals[$];                     // random command values

	// 50 mhz clock
	initial pclk = 1'b0;
	always #10 pclk = ~pclk;

	ccf_host ccf_host_inst (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	ccf_top #(.VALUE_MAX(VMAX)) ccf_top_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .supply_short_in(supply_short_in),
		.out_one_fault_in(out_one_fault_in),
		.param_invalid_in(param_invalid_in), .sync_event_in(sync_event_in),
		.compare_one_hit(compare_one_hit), .compare_two_hit(compare_two_hit),
		.count_dir_up(count_dir_up), .count_dir_down(count_dir_down),
		.digital_out_one(digital_out_one), .digital_out_two(digital_out_two),
		.gate_open(gate_open), .diag_message(diag_message),
		.count_value(count_value));

	// prints the counts and the verdict, then stops
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		ccf_host_inst.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		ccf_host_inst.xfer(1'b0, a, 32'h0, q, e);
	endtask
	task automatic set_ctl(input logic [12:0] c);
		ctl = c;
		wr(8'h04, {19'h0, c});
		repeat (2) @(posedge pclk);
	endtask

	// count, pending, comparison and output parameter registers and the load error bit against the model
	task automatic check_all();
		logic [31:0] q;
		rd(8'h0c, q);
		`CHK(q, m_cnt)
		rd(8'h10, q);
		`CHK(q, m_pend)
		rd(8'h14, q);
		`CHK(q, m_c1)
		rd(8'h18, q);
		`CHK(q, m_c2)
		rd(8'h1c, q);
		`CHK(q, m_op)
		rd(8'h08, q);
		`CHK(q[2], m_lerr)
	endtask

	// one command pulse of kind k, with optional extra command bits
	task automatic cmd(input int k, input logic [31:0] v,
		input logic [12:0] xtra);
		logic ok;
		wr(8'h00, v);
		wr(8'h04, {19'h0, ctl | (13'h0100 << k) | xtra});
		repeat (3) @(posedge pclk);
		wr(8'h04, {19'h0, ctl});
		repeat (3) @(posedge pclk);
		// one command alone, a legal value and legal parameters
		ok = (xtra == 13'h0);
		if (k < 4 && v > VMAX)
			ok = 1'b0;
		if (k == 4 && (v[2:0] > 3'h4 || (v & 32'hff0000c8) != 32'h0))
			ok = 1'b0;
		if (k == 4 && v[2:0] == 3'h4 && !(m_c1 < m_c2))
			ok = 1'b0;
		if (ok) begin
			case (k)
				0: m_cnt = v;
				1: m_pend = v;
				2: m_c1 = v;
				3: m_c2 = v;
				default: m_op = v & 32'h00ffff37;
			endcase
		end
		m_lerr = !ok;
		check_all();
	endtask

	// status reset handshake, host side
	task automatic sts_reset(input logic exp5);
		logic [31:0] q;
		set_ctl(ctl | 13'h0004);
		rd(8'h08, q);
		`CHK(q[4], 1'b1)
		set_ctl(ctl & ~13'h0004);
		rd(8'h08, q);
		`CHK(q[4], 1'b0)
		`CHK(q[5], exp5)
	endtask

	// watchdog against a hang
	initial begin
		#200000;
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_sim();
	end

	// main sequence
	initial begin
		logic [31:0] q;
		logic        e;
		int          i;
		{presetn, supply_short_in, out_one_fault_in, param_invalid_in} = 4'h0;
		{sync_event_in, compare_one_hit, compare_two_hit} = 3'h0;
		{count_dir_up, count_dir_down} = 2'h0;
		{m_cnt, m_pend, m_c1, m_c2, m_op} = 160'h0;
		{n_fail, cmp_count, ctl, m_lerr} = 0;
		void'($urandom(32'he082));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		ccf_host_inst.xfer(1'b0, 8'h20, 32'h0, q, e);
		`CHK(e, 1'b1)
		`CHK(q, 32'h0)
		rd(8'h08, q);
		`CHK(q, 32'h0)
		for (i = 0; i < 4; i++)
			vals.push_back($urandom & VMAX);
		for (i = 0; i < 4; i++)
			cmd(i, vals[i], 13'h0);
		cmd(0, VMAX, 13'h0);
		cmd(0, VMAX + 32'h1, 13'h0);
		cmd(2, $urandom & VMAX, 13'h0800);
		cmd(4, {8'h00, 8'($urandom), 8'($urandom), 8'h31}, 13'h0);
		set_ctl(13'h0010);
		compare_one_hit <= 1'b1;
		repeat (2) @(posedge pclk);
		`CHK(digital_out_one, 1'b1)
		compare_one_hit <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK(digital_out_one, 1'b0)
		set_ctl(13'h0000);
		cmd(4, 32'h00000005, 13'h0);
		cmd(4, 32'h00000008, 13'h0);
		cmd(2, 32'h0000000a, 13'h0);
		cmd(3, 32'h00000005, 13'h0);
		cmd(4, 32'h00000004, 13'h0);
		cmd(3, 32'h00000014, 13'h0);
		cmd(4, 32'h00000004, 13'h0);
		cmd(4, 32'h00000000, 13'h0);
		for (i = 0; i < 16; i++) begin
			set_ctl({6'h0, i[3:0], 3'h0});
			`CHK(digital_out_one, i[1] & i[0])
			`CHK(digital_out_two, i[3] & i[2])
		end
		set_ctl(13'h0000);
		sts_reset(1'b0);
		set_ctl(13'h0008);
		rd(8'h08, q);
		`CHK(q[5], 1'b1)
		set_ctl(13'h0018);
		sts_reset(1'b1);
		set_ctl(13'h0000);
		sts_reset(1'b0);
		set_ctl(13'h0001);
		`CHK(gate_open, 1'b1)
		rd(8'h08, q);
		`CHK(q[10], 1'b1)
		set_ctl(13'h0000);
		`CHK(gate_open, 1'b0)
		cmd(1, ~m_cnt & VMAX, 13'h0);
		sync_event_in <= 1'b1;
		repeat (2) @(posedge pclk);
		sync_event_in <= 1'b0;
		check_all();
		rd(8'h08, q);
		`CHK(q[7], 1'b0)
		set_ctl(13'h0002);
		sync_event_in <= 1'b1;
		repeat (2) @(posedge pclk);
		sync_event_in <= 1'b0;
		m_cnt = m_pend;
		set_ctl(13'h0000);
		check_all();
		rd(8'h08, q);
		`CHK(q[7], 1'b1)
		supply_short_in <= 1'b1;
		out_one_fault_in <= 1'b1;
		repeat (2) @(posedge pclk);
		supply_short_in <= 1'b0;
		out_one_fault_in <= 1'b0;
		repeat (2) @(posedge pclk);
		rd(8'h08, q);
		`CHK(q[1:0], 2'b11)
		`CHK(diag_message, 1'b1)
		set_ctl(13'h0080);
		set_ctl(13'h0000);
		rd(8'h08, q);
		`CHK(q[1:0], 2'b00)
		`CHK(diag_message, 1'b0)
		param_invalid_in <= 1'b1;
		repeat (2) @(posedge pclk);
		rd(8'h08, q);
		`CHK(q[3], 1'b1)
		param_invalid_in <= 1'b0;
		end_sim();
	end
endmodule

bind ccf_top ccf_assertions #(.VALUE_MAX(VALUE_MAX)) ccf_assertions_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .supply_short_in(supply_short_in),
	.digital_out_one(digital_out_one), .digital_out_two(digital_out_two),
	.gate_open(gate_open), .diag_message(diag_message),
	.count_value(count_value));
